// ==== hdl/lfcr_pkg.sv ====
// Package for the LF receiver configuration register bank.
// Assumes an 8-bit internal SFR bus with byte addresses.
package lfcr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RX_DATA = 8'hA5;
  localparam logic [7:0] OFS_FILT_GAIN = 8'hB6;
  localparam logic [7:0] OFS_THR_DIV = 8'hB7;
  localparam logic [7:0] OFS_PAT_CFG = 8'hC7;
  localparam logic [7:0] OFS_RX_CTRL = 8'hB4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RX_DATA = 8'h00;
  localparam logic [7:0] RST_FILT_GAIN = 8'h31;
  localparam logic [7:0] RST_THR_DIV = 8'h39;
  localparam logic [7:0] RST_PAT_CFG = 8'h00;
  localparam logic [7:0] RST_RX_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // Writable bit masks (reserved bits clear)
  // ----------------------------------------------------------------
  localparam logic [7:0] MSK_PAT_CFG = 8'h07;
  localparam logic [7:0] MSK_FILT_GAIN = 8'hFB;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCFG_PSEL = 0;
  localparam int PCFG_LEN_LO = 1;
  localparam int PCFG_LEN_HI = 2;
  localparam int THR_CD_LO = 4;
  localparam int THR_CD_HI = 7;
  localparam int THR_ATT_LO = 2;
  localparam int THR_ATT_HI = 3;
  localparam int THR_DIV_LO = 0;
  localparam int THR_DIV_HI = 1;
  localparam int FLT_DECAY_LO = 6;
  localparam int FLT_DECAY_HI = 7;
  localparam int FLT_SLICER_LO = 4;
  localparam int FLT_SLICER_HI = 5;
  localparam int FLT_GAIN = 3;
  localparam int FLT_DF_LO = 0;
  localparam int FLT_DF_HI = 1;
  localparam int CTL_RECAL = 7;
  localparam int CTL_AGC_OFF = 6;
  localparam int CTL_BBM_LO = 4;
  localparam int CTL_BBM_HI = 5;
  localparam int CTL_TIMER = 3;
  localparam int CTL_ENABLE = 2;
  localparam int CTL_INVERT = 1;
  localparam int CTL_CHOICE = 0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN_4BIT = 2'h0;
  localparam logic [1:0] LEN_8BIT = 2'h1;
  localparam logic [1:0] LEN_16BIT = 2'h2;
  localparam logic [1:0] LEN_RSVD = 2'h3;
  localparam logic [1:0] DIV_BY9 = 2'h0;
  localparam logic [1:0] DIV_BY1 = 2'h1;
  localparam logic [1:0] DIV_BY29 = 2'h2;
  localparam logic [1:0] DIV_RSVD = 2'h3;
  localparam logic [1:0] BBM_OFF = 2'h0;

  // Decoder modes as {invert, choice}
  typedef enum logic [1:0] {
    LFCR_DEC_MANCH = 2'h0,
    LFCR_DEC_BIPH0 = 2'h1,
    LFCR_DEC_IMANCH = 2'h2,
    LFCR_DEC_BIPH1 = 2'h3
  } lfcr_dec_t;

endpackage

// ==== hdl/lfcr_stream_if.sv ====
// Valid/ready byte stream between the bank and its buffer.
// Assumes both ends share one clock.
interface lfcr_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== hdl/lfcr_buf2.sv ====
// Two-entry buffer for decoded receiver bytes.
// Assumes synchronous inputs; asynchronous active-high reset.
module lfcr_buf2 #(
  parameter int W = 8
) (
  input wire logic clk_i,         // System clock
  input wire logic rst_i,         // Async reset, high
  lfcr_stream_if.snk in_s,        // Filling side
  lfcr_stream_if.src out_s        // Draining side
);

  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic push, pop;
  logic rdy_q, rdy_d;

  // ----------------------------------------------------------------
  // Handshakes and status
  // ----------------------------------------------------------------
  assign in_s.ready = rdy_q;
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data = mem_q[rd_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // Next pointer, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_s.data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
    // Ready is registered so the filling side sees a flop
    rdy_d = (cnt_d != 2'h2);
  end

  // Register state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      rdy_q <= rdy_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_buf_full_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_q == 2'h2) |-> !in_s.ready) else $error("buffer full but ready");
  a_buf_keep_word: assert property (@(posedge clk_i) disable iff (rst_i)
    (out_s.valid && !out_s.ready && !push) |=> out_s.valid && $stable(out_s.data))
    else $error("held word lost");

endmodule

// ==== hdl/lfcr_bank.sv ====
// LF wake-up receiver configuration and receive-data registers.
// Assumes the core's SFR bus with one-cycle read and write strobes,
// the pattern matcher, on/off timer and decoder as neighbours.

// Notes on behaviour
// - Length code selects 4, 8 or 16 bit pattern compare; code 11 reserved.
// - Select bit 0: only pattern zero matches cause a wake-up.
// - Select bit 1: a match on either pattern causes a wake-up.
// - Top four threshold bits drive the carrier detector level.
// - Divider code: 00 by 9, 01 by 1, 10 by 29, 11 reserved.
// - Control bit 6 set disables gain control; clear keeps it active.
// - Baseband mode 00 disables the baseband processor.
// - Timer enable 0 keeps receiver on; 1 lets on/off timer gate it.
// - Receiver enable 0 turns the receiver off.
// - Invert bit set inverts receiver data before decoding.
// - Without inversion, choice bit selects Manchester or biphase 0.
// - With inversion, choice bit selects inverted Manchester or biphase 1.
// - Receive data register is read-only and loads the buffered bytes oldest first.
// - Pending flag sets when a new byte lands in receive data.
// - Decode error sets a flag; status read clears it.
module lfcr_bank
  import lfcr_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk_i,                    // System clock
  input wire logic rst_i,                    // Async reset, high
  input wire logic [7:0] sfr_addr_i,         // SFR address
  input wire logic [7:0] sfr_wdata_i,        // SFR write data
  input wire logic sfr_wr_i,                 // SFR write strobe
  input wire logic sfr_rd_i,                 // SFR read strobe
  output logic [7:0] sfr_rdata_o,            // SFR read data
  input wire logic match_p0_i,               // Pattern zero matched
  input wire logic match_p1_i,               // Pattern one matched
  output logic pattern_wake_o,               // Pattern wake-up
  output logic [1:0] pattern_length_code_o,  // Compare length code
  output logic [3:0] carrier_threshold_o,    // Detector level
  output logic [1:0] attenuator_threshold_o, // Attenuator code
  output logic [1:0] antenna_divider_o,      // Divider code
  output logic [1:0] gain_decay_slew_o,      // Decay slew code
  output logic [1:0] slicer_filter_o,        // Slicer corner code
  output logic front_end_gain_o,             // Front-end gain
  output logic [1:0] data_filter_o,          // Data filter code
  output logic recal_o,                      // Threshold recal
  output logic agc_enable_o,                 // Gain control active
  output logic [1:0] baseband_mode_o,        // Baseband mode
  output logic baseband_on_o,                // Baseband enabled
  input wire logic timer_on_i,               // On/off timer phase
  output logic receiver_power_o,             // Receiver powered
  input wire logic rx_raw_i,                 // Raw receiver data
  output logic rx_data_o,                    // Data to decoder
  output logic [1:0] decoder_mode_o,         // Decoder selection
  input wire logic [W-1:0] dec_byte_i,       // Decoded byte
  input wire logic dec_valid_i,              // Decoded byte valid
  output logic dec_ready_o,                  // Buffer can take byte
  input wire logic dec_error_i,              // Decode error pulse
  input wire logic status_rd_i,              // Status register read
  output logic byte_pending_flag_o,          // New byte pending
  output logic decode_error_flag_o           // Decode error seen
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] pcfg_q, pcfg_d;
  logic [7:0] thr_q, thr_d;
  logic [7:0] filt_q, filt_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [W-1:0] rxd_q, rxd_d;
  logic pend_q, pend_d;
  logic derr_q, derr_d;
  logic [7:0] rdata_q, rdata_d;
  logic wake_q, wake_d;
  logic power_q, power_d;
  logic data_q, data_d;
  logic agc_q, agc_d;
  logic bbon_q, bbon_d;
  logic wr_pcfg, wr_thr, wr_filt, wr_ctrl, rd_rxd;
  logic drain;

  // Buffer carrier
  lfcr_stream_if #(.W(W)) fill_s ();
  lfcr_stream_if #(.W(W)) drain_s ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_pcfg = sfr_wr_i && (sfr_addr_i == OFS_PAT_CFG);
  assign wr_thr = sfr_wr_i && (sfr_addr_i == OFS_THR_DIV);
  assign wr_filt = sfr_wr_i && (sfr_addr_i == OFS_FILT_GAIN);
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == OFS_RX_CTRL);
  assign rd_rxd = sfr_rd_i && (sfr_addr_i == OFS_RX_DATA);

  // ----------------------------------------------------------------
  // Decoded byte buffer
  // ----------------------------------------------------------------
  assign fill_s.valid = dec_valid_i;
  assign fill_s.data = dec_byte_i;
  assign dec_ready_o = fill_s.ready;
  // Drain only when the pending flag is clear, after a receive data or status read
  assign drain_s.ready = !pend_q;
  assign drain = drain_s.valid && drain_s.ready;

  lfcr_buf2 #(.W(W)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Next values of the writable registers
  always_comb begin
    pcfg_d = pcfg_q;
    thr_d = thr_q;
    filt_d = filt_q;
    ctrl_d = ctrl_q;
    if (wr_pcfg) begin
      pcfg_d = sfr_wdata_i & MSK_PAT_CFG;
      if (sfr_wdata_i[PCFG_LEN_HI:PCFG_LEN_LO] == LEN_RSVD) begin
        pcfg_d[PCFG_LEN_HI:PCFG_LEN_LO] = pcfg_q[PCFG_LEN_HI:PCFG_LEN_LO];
      end
    end
    if (wr_thr) begin
      thr_d = sfr_wdata_i;
      if (sfr_wdata_i[THR_DIV_HI:THR_DIV_LO] == DIV_RSVD) begin
        thr_d[THR_DIV_HI:THR_DIV_LO] = thr_q[THR_DIV_HI:THR_DIV_LO];
      end
    end
    if (wr_filt) begin
      filt_d = sfr_wdata_i & MSK_FILT_GAIN;
    end
    if (wr_ctrl) begin
      ctrl_d = sfr_wdata_i;
    end
    // Decoded control outputs follow the next control value
    agc_d = !ctrl_d[CTL_AGC_OFF];
    bbon_d = (ctrl_d[CTL_BBM_HI:CTL_BBM_LO] != BBM_OFF);
  end

  // Register the configuration
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pcfg_q <= RST_PAT_CFG;
      thr_q <= RST_THR_DIV;
      filt_q <= RST_FILT_GAIN;
      ctrl_q <= RST_RX_CTRL;
      agc_q <= !RST_RX_CTRL[CTL_AGC_OFF];
      bbon_q <= (RST_RX_CTRL[CTL_BBM_HI:CTL_BBM_LO] != BBM_OFF);
    end else begin
      pcfg_q <= pcfg_d;
      thr_q <= thr_d;
      filt_q <= filt_d;
      ctrl_q <= ctrl_d;
      agc_q <= agc_d;
      bbon_q <= bbon_d;
    end
  end

  // ----------------------------------------------------------------
  // Receive data and flags
  // ----------------------------------------------------------------
  // Byte capture, pending and error flags; a set beats a clear
  always_comb begin
    rxd_d = rxd_q;
    pend_d = pend_q;
    derr_d = derr_q;
    if (rd_rxd || status_rd_i) begin
      pend_d = 1'b0;
    end
    if (drain) begin
      rxd_d = drain_s.data;
      pend_d = 1'b1;
    end
    if (status_rd_i) begin
      derr_d = 1'b0;
    end
    if (dec_error_i) begin
      derr_d = 1'b1;
    end
  end

  // Register data and flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_q <= RST_RX_DATA[W-1:0];
      pend_q <= 1'b0;
      derr_q <= 1'b0;
    end else begin
      rxd_q <= rxd_d;
      pend_q <= pend_d;
      derr_q <= derr_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_d = 8'h00;
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        OFS_PAT_CFG: rdata_d = pcfg_q;
        OFS_THR_DIV: rdata_d = thr_q;
        OFS_FILT_GAIN: rdata_d = filt_q;
        OFS_RX_CTRL: rdata_d = ctrl_q;
        OFS_RX_DATA: rdata_d = 8'(rxd_q);
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Receiver gating, wake-up and data path
  // ----------------------------------------------------------------
  // Next wake, power and data values
  always_comb begin
    wake_d = match_p0_i || (pcfg_q[PCFG_PSEL] && match_p1_i);
    power_d = 1'b0;
    if (ctrl_q[CTL_ENABLE]) begin
      power_d = !ctrl_q[CTL_TIMER] || timer_on_i;
    end
    data_d = rx_raw_i ^ ctrl_q[CTL_INVERT];
  end

  // Register the derived outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_q <= 1'b0;
      power_q <= 1'b0;
      data_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
      power_q <= power_d;
      data_q <= data_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata_o = rdata_q;
  assign pattern_wake_o = wake_q;
  assign pattern_length_code_o = pcfg_q[PCFG_LEN_HI:PCFG_LEN_LO];
  assign carrier_threshold_o = thr_q[THR_CD_HI:THR_CD_LO];
  assign attenuator_threshold_o = thr_q[THR_ATT_HI:THR_ATT_LO];
  assign antenna_divider_o = thr_q[THR_DIV_HI:THR_DIV_LO];
  assign gain_decay_slew_o = filt_q[FLT_DECAY_HI:FLT_DECAY_LO];
  assign slicer_filter_o = filt_q[FLT_SLICER_HI:FLT_SLICER_LO];
  assign front_end_gain_o = filt_q[FLT_GAIN];
  assign data_filter_o = filt_q[FLT_DF_HI:FLT_DF_LO];
  assign recal_o = ctrl_q[CTL_RECAL];
  assign agc_enable_o = agc_q;
  assign baseband_mode_o = ctrl_q[CTL_BBM_HI:CTL_BBM_LO];
  assign baseband_on_o = bbon_q;
  assign receiver_power_o = power_q;
  assign rx_data_o = data_q;
  // Decoder mode pairs invert and choice bits
  assign decoder_mode_o = {ctrl_q[CTL_INVERT], ctrl_q[CTL_CHOICE]};
  assign byte_pending_flag_o = pend_q;
  assign decode_error_flag_o = derr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_drain;
    drain_s.valid && drain_s.ready;
  endsequence

  sequence s_ctrl_write;
    wr_ctrl;
  endsequence

  a_len_reserved_kept: assert property (
    (wr_pcfg && sfr_wdata_i[PCFG_LEN_HI:PCFG_LEN_LO] == LEN_RSVD) |=> $stable(pattern_length_code_o))
    else $error("reserved length code stored");
  a_wake_only_zero: assert property (
    (!pcfg_q[PCFG_PSEL] && match_p1_i && !match_p0_i) |=> !pattern_wake_o)
    else $error("pattern one woke with select clear");
  a_wake_either_one: assert property (
    (pcfg_q[PCFG_PSEL] && (match_p0_i || match_p1_i)) |=> pattern_wake_o)
    else $error("match missed with select set");
  a_thr_drive_write: assert property (
    wr_thr |=> carrier_threshold_o == $past(sfr_wdata_i[THR_CD_HI:THR_CD_LO]))
    else $error("threshold not driven");
  a_agc_follow_ctrl: assert property (
    s_ctrl_write |=> agc_enable_o == !$past(sfr_wdata_i[CTL_AGC_OFF]))
    else $error("gain control state wrong");
  a_bb_off_mode: assert property (
    (s_ctrl_write ##0 (sfr_wdata_i[CTL_BBM_HI:CTL_BBM_LO] == BBM_OFF)) |=> !baseband_on_o)
    else $error("baseband on in mode 00");
  a_power_continuous: assert property (
    (ctrl_q[CTL_ENABLE] && !ctrl_q[CTL_TIMER] && !wr_ctrl) |=> receiver_power_o)
    else $error("receiver not continuously on");
  a_power_timer_gate: assert property (
    (ctrl_q[CTL_ENABLE] && ctrl_q[CTL_TIMER] && !timer_on_i) |=> !receiver_power_o)
    else $error("timer gating ignored");
  a_power_disabled: assert property (
    !ctrl_q[CTL_ENABLE] |=> !receiver_power_o)
    else $error("receiver on while disabled");
  a_data_invert_path: assert property (
    1'b1 |=> rx_data_o == ($past(rx_raw_i) ^ $past(ctrl_q[CTL_INVERT])))
    else $error("receiver data polarity wrong");
  a_rxd_write_ignored: assert property (
    (sfr_wr_i && sfr_addr_i == OFS_RX_DATA && !drain) |=> $stable(rxd_q))
    else $error("receive data altered by write");
  a_pending_on_byte: assert property (
    s_drain |=> byte_pending_flag_o && rxd_q == $past(drain_s.data))
    else $error("byte landed without pending");
  a_decode_error_flag_set_clear: assert property (
    (dec_error_i |=> decode_error_flag_o) and
    ((status_rd_i && !dec_error_i) |=> !decode_error_flag_o))
    else $error("decode error flag wrong");
  a_reserved_read_zero: assert property (
    (sfr_rd_i && sfr_addr_i == OFS_PAT_CFG) |=> sfr_rdata_o[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  a_div_reserved_kept: assert property (
    (wr_thr && sfr_wdata_i[THR_DIV_HI:THR_DIV_LO] == DIV_RSVD) |=> $stable(antenna_divider_o))
    else $error("reserved divider code stored");
  a_dec_mode_follow: assert property (
    s_ctrl_write |=> decoder_mode_o == $past(sfr_wdata_i[CTL_INVERT:CTL_CHOICE]))
    else $error("decoder selection wrong");

endmodule

// ==== test/lfcr_front_model.sv ====
// Model of the LF front end: raw data line and decoded-byte source.
// Assumes the bank's valid/ready byte port and one system clock.
module lfcr_front_model (
  input wire logic clk_i,        // System clock
  input wire logic rst_i,        // Async reset, high
  input wire logic dec_ready_i,  // Bank can take byte
  output logic [7:0] dec_byte_o, // Decoded byte
  output logic dec_valid_o,      // Byte valid
  output logic dec_error_o,      // Decode error pulse
  output logic rx_raw_o          // Raw receiver data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic [7:0] last_b = 8'h00;
  logic took = 1'b0;
  initial begin
    dec_byte_o = 8'hFF;
    dec_valid_o = 1'b0;
    dec_error_o = 1'b0;
    rx_raw_o = 1'b0;
  end
  // Note a take at the rising edge
  always @(posedge clk_i or posedge rst_i) begin
    took <= rst_i ? 1'b0 : (dec_valid_o & dec_ready_i);
  end
  // Advance queue; idle data shows the inverse of the last byte
  always @(negedge clk_i) begin
    if (took && q.size() > 0) begin
      last_b = q.pop_front();
    end
    dec_valid_o = (q.size() > 0);
    dec_byte_o = (q.size() > 0) ? q[0] : ~last_b;
  end
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  task automatic set_raw(input logic v);
    rx_raw_o = v;
  endtask
  // One-cycle error pulse, called at a falling edge
  task automatic err();
    dec_error_o = 1'b1;
    @(negedge clk_i);
    dec_error_o = 1'b0;
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the LF receiver register bank.
// Assumes lfcr_pkg, the bank with its buffer, and the front-end model.
module testbench
  import lfcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr_i, sfr_wdata_i;
  logic sfr_wr_i, sfr_rd_i, match_p0_i, match_p1_i, timer_on_i, status_rd_i;
  logic rx_raw_i, dec_valid_i, dec_error_i, dec_ready_o, pattern_wake_o, front_end_gain_o, recal_o;
  logic agc_enable_o, baseband_on_o, receiver_power_o, rx_data_o, byte_pending_flag_o, decode_error_flag_o;
  logic [7:0] sfr_rdata_o, dec_byte_i, e;
  logic [3:0] carrier_threshold_o;
  logic [1:0] pattern_length_code_o, attenuator_threshold_o, antenna_divider_o, gain_decay_slew_o;
  logic [1:0] slicer_filter_o, data_filter_o, baseband_mode_o, decoder_mode_o;
  int err_total = 0;
  int checks = 0;
  // Outputs regrouped in register bit order
  wire [7:0] thr_v = {carrier_threshold_o, attenuator_threshold_o, antenna_divider_o};
  wire [7:0] filt_v = {gain_decay_slew_o, slicer_filter_o, front_end_gain_o, 1'b0, data_filter_o};
  wire [7:0] ctl_v = {recal_o, ~agc_enable_o, baseband_mode_o, 2'b00, decoder_mode_o};

  always #5 clk_i = ~clk_i;

  lfcr_bank #(.W(8)) DUT (
    .clk_i, .rst_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .match_p0_i,
    .match_p1_i, .pattern_wake_o, .pattern_length_code_o, .carrier_threshold_o, .attenuator_threshold_o,
    .antenna_divider_o, .gain_decay_slew_o, .slicer_filter_o, .front_end_gain_o, .data_filter_o,
    .recal_o, .agc_enable_o, .baseband_mode_o, .baseband_on_o, .timer_on_i, .receiver_power_o,
    .rx_raw_i, .rx_data_o, .decoder_mode_o, .dec_byte_i, .dec_valid_i, .dec_ready_o, .dec_error_i,
    .status_rd_i, .byte_pending_flag_o, .decode_error_flag_o
  );
  lfcr_front_model front (.clk_i, .rst_i, .dec_ready_i(dec_ready_o), .dec_byte_o(dec_byte_i),
    .dec_valid_o(dec_valid_i), .dec_error_o(dec_error_i), .rx_raw_o(rx_raw_i));

  // --------------------------------------------------------------
  // Compare and bus tasks
  // --------------------------------------------------------------
  task automatic chk_v(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checks++;
    if (got !== ex) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_b(input string nm, input logic ex, input logic got);
    checks++;
    if (got !== ex) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, ex, got);
    end
  endtask
  // Strobes start and end at falling edges, one idle cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] ex);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    chk_v($sformatf("reg_%h", a), ex, sfr_rdata_o);
    @(negedge clk_i);
  endtask
  task automatic wake(input logic p0, input logic p1, input logic ex);
    match_p0_i = p0;
    match_p1_i = p1;
    @(negedge clk_i);
    match_p0_i = 1'b0;
    match_p1_i = 1'b0;
    chk_b("wake", ex, pattern_wake_o);
    @(negedge clk_i);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    rdchk(OFS_THR_DIV, RST_THR_DIV);
    rdchk(OFS_FILT_GAIN, RST_FILT_GAIN);
    rdchk(OFS_PAT_CFG, RST_PAT_CFG);
    rdchk(OFS_RX_DATA, RST_RX_DATA);
    rdchk(8'hA0, 8'h00);
    for (int d = 0; d < 4; d++) begin
      wr(OFS_THR_DIV, {4'hA, 2'h2, 2'(d)});
      e = {4'hA, 2'h2, (d == 3) ? 2'h2 : 2'(d)};
      chk_v("thr_out", e, thr_v);
      rdchk(OFS_THR_DIV, e);
    end
    wr(OFS_FILT_GAIN, 8'hFF);
    rdchk(OFS_FILT_GAIN, 8'hFB);
    wr(OFS_FILT_GAIN, 8'h09);
    chk_v("filt_out", 8'h09, filt_v);
    $display("test registers done");
  endtask
  task automatic t_pattern();
    for (int l = 0; l < 4; l++) begin
      wr(OFS_PAT_CFG, {5'h1F, 2'(l), 1'b0});
      e = {5'h00, (l == 3) ? 2'h2 : 2'(l), 1'b0};
      chk_v("length", e, {5'h00, pattern_length_code_o, 1'b0});
      rdchk(OFS_PAT_CFG, e);
    end
    wake(1'b0, 1'b1, 1'b0);
    wake(1'b1, 1'b0, 1'b1);
    wr(OFS_PAT_CFG, 8'h05);
    wake(1'b0, 1'b1, 1'b1);
    $display("test pattern done");
  endtask
  task automatic t_control();
    logic [7:0] cv [5] = '{8'h40, 8'h10, 8'h20, 8'h30, 8'h00};
    logic [9:0] pt [5] = '{{8'h04, 2'b01}, {8'h0C, 2'b00}, {8'h0C, 2'b11}, {8'h08, 2'b10}, {8'h04, 2'b11}};
    for (int m = 0; m < 4; m++) begin
      wr(OFS_RX_CTRL, {6'h00, 2'(m)});
      chk_v("decoder", {6'h00, 2'(m)}, ctl_v);
      front.set_raw(1'b1);
      @(negedge clk_i);
      chk_b("rx_data", !m[1], rx_data_o);
      front.set_raw(1'b0);
      @(negedge clk_i);
      chk_b("rx_data", m[1], rx_data_o);
    end
    foreach (cv[i]) begin
      wr(OFS_RX_CTRL, cv[i]);
      chk_v("ctrl_out", cv[i], ctl_v);
      chk_b("bb_on", cv[i][5:4] != 2'b00, baseband_on_o);
      rdchk(OFS_RX_CTRL, cv[i]);
    end
    foreach (pt[i]) begin
      timer_on_i = pt[i][1];
      wr(OFS_RX_CTRL, pt[i][9:2]);
      chk_b("power", pt[i][0], receiver_power_o);
    end
    $display("test control done");
  endtask
  task automatic t_stream();
    int n;
    front.push(8'hA1);
    front.push(8'hB2);
    front.push(8'hC3);
    repeat (8) @(negedge clk_i);
    chk_b("ready", 1'b0, dec_ready_o);
    for (int i = 0; i < 3; i++) begin
      n = 0;
      while (byte_pending_flag_o !== 1'b1 && n < 20) begin
        @(negedge clk_i);
        n++;
      end
      chk_b("pending", 1'b1, byte_pending_flag_o);
      rdchk(OFS_RX_DATA, 8'hA1 + 8'(i * 17));
    end
    chk_b("pending", 1'b0, byte_pending_flag_o);
    chk_b("ready", 1'b1, dec_ready_o);
    wr(OFS_RX_DATA, 8'h00);
    rdchk(OFS_RX_DATA, 8'hC3);
    front.err();
    chk_b("dec_err", 1'b1, decode_error_flag_o);
    status_rd_i = 1'b1;
    front.err();
    status_rd_i = 1'b0;
    chk_b("dec_err", 1'b1, decode_error_flag_o);
    @(negedge clk_i);
    status_rd_i = 1'b1;
    @(negedge clk_i);
    status_rd_i = 1'b0;
    chk_b("dec_err", 1'b0, decode_error_flag_o);
    $display("test stream done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the under two hundred cycles the tests need
  initial begin
    #100us;
    err_total++;
    summarize();
  end
  initial begin
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    match_p0_i = 1'b0;
    match_p1_i = 1'b0;
    timer_on_i = 1'b0;
    status_rd_i = 1'b0;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_regs();
    t_pattern();
    t_control();
    t_stream();
    summarize();
  end
endmodule
